// ==== src/id_link_master.v ====
// Bus master that resets the single-wire line, issues a command and reads or searches identity.
`timescale 1ns/1ps
`default_nettype none
`include "id_link_map.vh"
module id_link_master #(
    parameter CLOCK_KHZ = `CLOCK_KHZ,
    parameter RESET_LOW_CYCLES  = (`RESET_LOW_TIME_US * CLOCK_KHZ + 999) / 1000,
    parameter RESET_HIGH_CYCLES = (`RESET_HIGH_TIME_US * CLOCK_KHZ + 999) / 1000
) (
    // Clock and reset.
    input  wire        clock,
    input  wire        rst,
    // Command request: code is one of the command codes; choose steers enumeration.
    input  wire        start,
    input  wire [7:0]  command,
    input  wire [63:0] choose,
    output reg         busy,
    // Result words: {presence, crc_ok, identity}.
    output reg         result_valid,
    input  wire        result_ready,
    output reg  [65:0] result_data,
    // Line pin, open drain: oe_n low means pulled low.
    input  wire        line_in,
    output reg         line_out,
    output reg         line_oe_n
);
    localparam integer WRITE_LOW  = (`WRITE_ONE_LOW_TIME_US * CLOCK_KHZ + 999) / 1000;
    localparam integer ZERO_LOW   = (`WRITE_ZERO_LOW_US * CLOCK_KHZ + 999) / 1000;
    localparam integer READ_SAMP  = (`READ_SAMPLE_US * CLOCK_KHZ) / 1000;
    localparam integer SLOT       = (`SLOT_TIME_US * CLOCK_KHZ + 999) / 1000;
    localparam integer RECOVER    = (`RECOVERY_US * CLOCK_KHZ + 999) / 1000;
    localparam integer PRES_SAMP  = (`PRESENCE_SAMPLE_US * CLOCK_KHZ + 999) / 1000;
    localparam [6:0] S_IDLE  = 7'h01;
    localparam [6:0] S_RLOW  = 7'h02;
    localparam [6:0] S_RHIGH = 7'h04;
    localparam [6:0] S_SLOT  = 7'h08;
    localparam [6:0] S_REC   = 7'h10;
    localparam [6:0] S_NEXT  = 7'h20;
    localparam [6:0] S_DONE  = 7'h40;
    // Slot kinds.
    localparam [1:0] K_WRITE = 2'd0;
    localparam [1:0] K_READ  = 2'd1;
    localparam [1:0] K_COMP  = 2'd2;

    // ************************************************************
    // Pin synchroniser
    // ************************************************************
    reg        sync1, sync2, sync3, line_seen;
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
            sync3 <= 1'b1;
            line_seen <= 1'b1;
        end else begin
            sync1 <= line_in;
            sync2 <= sync1;
            sync3 <= sync2;
            if (sync2 == sync3) begin
                line_seen <= sync3;
            end
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    reg [6:0]  state;
    reg [15:0] timer;
    reg [1:0]  kind;
    reg        wbit;
    reg [7:0]  cmd;
    reg [63:0] pick;
    reg [63:0] ident;
    reg [6:0]  bitn;
    reg        in_cmd;
    reg        presence;
    reg        rbit;
    reg        read_val;
    reg        push;
    wire       buf_ready;
    wire       is_read   = (cmd == `CMD_READ_ID) || (cmd == `CMD_READ_ID_ALT);
    wire       is_search = (cmd == `CMD_ENUMERATE);

    // CRC over the first 56 received bits, least significant first.
    reg [7:0]  crc;
    integer    i;
    always @* begin
        crc = 8'h00;
        for (i = 0; i < `DATA_BITS; i = i + 1) begin
            crc = (crc[0] ^ ident[i]) ? ((crc >> 1) ^ `CRC_POLY_REFLECTED) : (crc >> 1);
        end
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= S_IDLE;
            timer <= 16'h0000;
            kind <= K_WRITE;
            wbit <= 1'b1;
            cmd <= 8'h00;
            pick <= 64'h0;
            ident <= 64'h0;
            bitn <= 7'h00;
            in_cmd <= 1'b0;
            presence <= 1'b0;
            rbit <= 1'b0;
            read_val <= 1'b0;
            push <= 1'b0;
            busy <= 1'b0;
            line_out <= 1'b0;
            line_oe_n <= 1'b1;
        end else begin
            push <= 1'b0;
            timer <= timer + 16'h0001;
            case (state)
                S_IDLE: begin
                    line_oe_n <= 1'b1;
                    timer <= 16'h0000;
                    // A result still on its way into the buffer counts as taking room.
                    if (start && !busy && buf_ready && !push) begin
                        cmd <= command;
                        pick <= choose;
                        ident <= 64'h0;
                        busy <= 1'b1;
                        line_oe_n <= 1'b0;
                        state <= S_RLOW;
                    end
                end
                S_RLOW: begin
                    if (timer == RESET_LOW_CYCLES[15:0]) begin
                        line_oe_n <= 1'b1;
                        timer <= 16'h0000;
                        presence <= 1'b0;
                        state <= S_RHIGH;
                    end
                end
                S_RHIGH: begin
                    if (timer == PRES_SAMP[15:0]) begin
                        presence <= !line_seen;
                    end
                    if (timer == RESET_HIGH_CYCLES[15:0]) begin
                        in_cmd <= 1'b1;
                        bitn <= 7'h00;
                        state <= S_NEXT;
                    end
                end
                S_NEXT: begin
                    // Choose the next slot; a missing presence ends the access.
                    timer <= 16'h0000;
                    if (!presence) begin
                        state <= S_DONE;
                    end else if (in_cmd) begin
                        kind <= K_WRITE;
                        wbit <= cmd[bitn[2:0]];
                        line_oe_n <= 1'b0;
                        state <= S_SLOT;
                    end else if (is_read || is_search) begin
                        kind <= K_READ;
                        line_oe_n <= 1'b0;
                        state <= S_SLOT;
                    end else begin
                        state <= S_DONE;
                    end
                end
                S_SLOT: begin
                    if (kind == K_WRITE && wbit && timer == WRITE_LOW[15:0]) begin
                        line_oe_n <= 1'b1;
                    end
                    if (kind != K_WRITE && timer == WRITE_LOW[15:0]) begin
                        line_oe_n <= 1'b1;
                    end
                    if (kind != K_WRITE && timer == READ_SAMP[15:0]) begin
                        rbit <= line_seen;
                    end
                    if (timer == ZERO_LOW[15:0] && kind == K_WRITE) begin
                        line_oe_n <= 1'b1;
                    end
                    if (timer == SLOT[15:0]) begin
                        timer <= 16'h0000;
                        state <= S_REC;
                    end
                end
                S_REC: begin
                    if (timer == RECOVER[15:0]) begin
                        state <= S_NEXT;
                        if (in_cmd) begin
                            bitn <= bitn + 7'h01;
                            if (bitn == 7'h07) begin
                                in_cmd <= 1'b0;
                                bitn <= 7'h00;
                            end
                        end else if (kind == K_READ) begin
                            read_val <= rbit;
                            if (is_search) begin
                                kind <= K_COMP;
                                timer <= 16'h0000;
                                line_oe_n <= 1'b0;
                                state <= S_SLOT;
                            end else begin
                                ident[bitn[5:0]] <= rbit;
                                bitn <= bitn + 7'h01;
                                if (bitn == 7'h3f) begin
                                    state <= S_DONE;
                                end
                            end
                        end else if (kind == K_COMP) begin
                            // Both ones: no device left taking part.
                            if (read_val && rbit) begin
                                presence <= 1'b0;
                            end else begin
                                kind <= K_WRITE;
                                wbit <= (read_val != rbit) ? read_val : pick[bitn[5:0]];
                                ident[bitn[5:0]] <= (read_val != rbit) ?
                                    read_val : pick[bitn[5:0]];
                                timer <= 16'h0000;
                                line_oe_n <= 1'b0;
                                state <= S_SLOT;
                            end
                        end else begin
                            bitn <= bitn + 7'h01;
                            kind <= K_READ;
                            if (bitn == 7'h3f) begin
                                state <= S_DONE;
                            end
                        end
                    end
                end
                S_DONE: begin
                    push <= 1'b1;
                    busy <= 1'b0;
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Result buffer
    // ************************************************************
    // The buffer keeps a stalled reader from losing a result; start waits for room.
    wire        buf_valid;
    wire [65:0] buf_data;
    wire        take = buf_valid && (!result_valid || result_ready);
    word_buffer #(.WIDTH(66)) results (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (buf_ready),
        // Several slaves answering a read give a wired-AND word, which the CRC flag exposes.
        .in_data   ({presence, crc == ident[63:56], ident}),
        .out_valid (buf_valid),
        .out_ready (take),
        .out_data  (buf_data)
    );
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            result_valid <= 1'b0;
            result_data <= 66'h0;
        end else if (take) begin
            result_valid <= 1'b1;
            result_data <= buf_data;
        end else if (result_ready) begin
            result_valid <= 1'b0;
        end
    end
endmodule // id_link_master
`default_nettype wire

// ==== src/id_link_map.vh ====
// Constants for the single-wire identity reader: command codes, timing and field layout.
`ifndef ID_LINK_MAP_VH
`define ID_LINK_MAP_VH
`define CLOCK_KHZ            40000
`define RESET_LOW_TIME_US    480
`define RESET_HIGH_TIME_US   480
`define PRESENCE_SAMPLE_US   70
`define WRITE_ONE_LOW_TIME_US 2
`define WRITE_ZERO_LOW_US    70
`define READ_SAMPLE_US       13
`define SLOT_TIME_US         70
`define RECOVERY_US          5
`define CMD_READ_ID          8'h33
`define CMD_READ_ID_ALT      8'h0f
`define CMD_SELECT           8'h55
`define CMD_ALL              8'hcc
`define CMD_ENUMERATE        8'hf0
`define CRC_POLY_REFLECTED   8'h8c
`define ID_BITS              64
`define DATA_BITS            56
`endif

// ==== src/word_buffer.v ====
// Two-entry valid/ready buffer for result words.
`timescale 1ns/1ps
`default_nettype none
module word_buffer #(
    parameter WIDTH = 66
) (
    // Clock and reset.
    input  wire             clock,
    input  wire             rst,
    // Fill side.
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side.
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] slot [0:1];
    reg             wr_ptr;
    reg             rd_ptr;
    reg [1:0]       count;
    wire            push;
    wire            pop;

    assign in_ready  = (count != 2'd2);
    assign out_valid = (count != 2'd0);
    assign out_data  = slot[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'd0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            if (push && !pop) begin
                count <= count + 2'd1;
            end else if (pop && !push) begin
                count <= count - 2'd1;
            end
        end
    end

    always @(posedge clock) begin
        if (push) begin
            slot[wr_ptr] <= in_data;
        end
    end
endmodule // word_buffer
`default_nettype wire

// ==== verification/id_link_properties.sv ====
// Timing and hand-shake checks on the identity reader's ports.
`timescale 1ns/1ps
`default_nettype none
module id_link_properties #(
    parameter int RESET_LOW_CYCLES  = 19200,
    parameter int RESET_HIGH_CYCLES = 19200,
    parameter int CYCLES_PER_US     = 40
) (
    // Clock and reset.
    input wire logic        clock,
    input wire logic        rst,
    // Request and result.
    input wire logic        start,
    input wire logic        busy,
    input wire logic        result_valid,
    input wire logic        result_ready,
    input wire logic [65:0] result_data,
    // Line pin.
    input wire logic        line_out,
    input wire logic        line_oe_n
);
    // ****************************************
    // Pulse counters
    // ****************************************
    // They saturate, so a line stuck for long cannot wrap them into a false pass.
    logic [15:0] low_cnt;
    logic [15:0] high_cnt;
    logic [15:0] gap_cnt;
    logic [7:0]  pulse_no;
    logic        oe_q;
    wire         fell_now = oe_q & ~line_oe_n;
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            low_cnt  <= 16'h0000;
            high_cnt <= 16'h0000;
            gap_cnt  <= 16'h0000;
            pulse_no <= 8'h00;
            oe_q     <= 1'b1;
        end else begin
            oe_q     <= line_oe_n;
            low_cnt  <= line_oe_n ? 16'h0000 : low_cnt + {15'h0000, ~&low_cnt};
            high_cnt <= line_oe_n ? high_cnt + {15'h0000, ~&high_cnt} : 16'h0000;
            gap_cnt  <= fell_now ? 16'h0001 : gap_cnt + {15'h0000, ~&gap_cnt};
            pulse_no <= !busy ? 8'h00 : pulse_no + {7'h00, fell_now & ~&pulse_no};
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence reset_end;
        $rose(line_oe_n) && pulse_no == 8'h01;
    endsequence
    sequence slot_end;
        $rose(line_oe_n) && pulse_no > 8'h01;
    endsequence
    sequence slot_begin;
        $fell(line_oe_n) && pulse_no > 8'h01;
    endsequence
    pin_low_only_a: assert property (line_out == 1'b0)
        else $error("line driven high");
    idle_release_a: assert property (!busy |-> line_oe_n)
        else $error("line pulled while idle");
    reset_first_a: assert property ($rose(busy) |-> ##[0:2] !line_oe_n)
        else $error("access did not open with a reset pulse");
    reset_low_a: assert property
        (reset_end |-> low_cnt >= RESET_LOW_CYCLES && low_cnt < 960 * CYCLES_PER_US)
        else $error("reset pulse length wrong");
    slot_low_a: assert property (slot_end |-> (low_cnt >= CYCLES_PER_US &&
        low_cnt <= 15 * CYCLES_PER_US) || (low_cnt >= 60 * CYCLES_PER_US &&
        low_cnt <= 120 * CYCLES_PER_US))
        else $error("slot low time wrong");
    reset_high_a: assert property
        ($fell(line_oe_n) && pulse_no == 8'h01 |-> high_cnt >= RESET_HIGH_CYCLES)
        else $error("first slot too soon after reset");
    recovery_gap_a: assert property (slot_begin |-> high_cnt >= CYCLES_PER_US)
        else $error("recovery gap too short");
    slot_rate_a: assert property (slot_begin |-> gap_cnt >= CYCLES_PER_US * 10000 / 163)
        else $error("slots too fast");
    start_taken_a: assert property (start && !busy && !result_valid |=> busy)
        else $error("start not taken");
    result_hold_a: assert property
        (result_valid && !result_ready |=> result_valid && $stable(result_data))
        else $error("result word dropped while stalled");
endmodule // id_link_properties
`default_nettype wire

// ==== verification/id_device_model.sv ====
// Behavioural identity device on the far side of the single-wire line.
`timescale 1ns/1ps
`default_nettype none
module id_device_model #(
    parameter int CYCLES_PER_US = 40
) (
    // Clock that times the device's own delays.
    input  wire logic        clock,
    // Scenario controls.
    input  wire logic        present,
    input  wire logic [63:0] id_word,
    // Shared line and the device's pull-down.
    input  wire logic        line,
    output logic             pull
);
    // ****************************************
    // Device behaviour
    // ****************************************
    localparam int RESET_SEEN = 120 * CYCLES_PER_US + 1;
    localparam int WAIT_PRES  = 30 * CYCLES_PER_US;
    localparam int LOW_PRES   = 100 * CYCLES_PER_US;
    localparam int SAMPLE     = 30 * CYCLES_PER_US;
    localparam int HOLD       = 15 * CYCLES_PER_US;
    int         low_n = 0;
    int         st    = 0;
    int         cnt   = 0;
    int         ph    = 0;
    logic [7:0] cmd   = 8'h00;
    initial pull = 1'b0;
    always @(posedge clock) low_n <= line ? 0 : low_n + 1;
    always begin
        @(posedge clock);
        if (present && low_n == RESET_SEEN) begin
            st = 0;
            wait (line === 1'b1);
            repeat (WAIT_PRES) @(posedge clock);
            st = 4;
            pull = 1'b1;
            repeat (LOW_PRES) @(posedge clock);
            pull = 1'b0;
            cnt = 0;
            st = 1;
        end
    end
    // Every slot is timed from the falling edge alone, as the real part does it.
    always @(negedge line) begin
        if (present && !pull) begin
            if (st == 1) begin
                repeat (SAMPLE) @(posedge clock);
                cmd = {line, cmd[7:1]};
                cnt = cnt + 1;
                if (cnt == 8) begin
                    st = (cmd == 8'h33 || cmd == 8'h0f) ? 2 : (cmd == 8'hf0) ? 3 : 0;
                    cnt = 0;
                    ph = 0;
                end
            end else if (st == 2 || (st == 3 && ph < 2)) begin
                pull = ~(id_word[cnt] ^ (ph == 1));
                repeat (HOLD) @(posedge clock);
                pull = 1'b0;
                if (st == 3) ph = ph + 1;
                else cnt = cnt + 1;
                if (cnt == 64) st = 0;
            end else if (st == 3) begin
                repeat (SAMPLE) @(posedge clock);
                if (line !== id_word[cnt]) st = 0;
                ph = 0;
                cnt = cnt + 1;
                if (cnt == 64) st = 0;
            end
        end
    end
endmodule // id_device_model
`default_nettype wire

// ==== verification/id_link_master_tb.sv ====
// Self-checking bench for the single-wire identity reader.
`timescale 1ns/1ps
`default_nettype none
module id_link_master_tb;
    // ****************************************
    // Bench
    // ****************************************
    logic        clock;
    logic        rst;
    logic        start;
    logic [7:0]  command;
    logic [63:0] choose;
    logic        result_ready;
    logic        present;
    logic [63:0] id_word;
    wire         busy;
    wire         result_valid;
    wire  [65:0] result_data;
    wire         line_out;
    wire         line_oe_n;
    wire         pull;
    // The pull-up holds the line high whenever nobody pulls it.
    wire         line = (line_oe_n | line_out) & ~pull;
    int          err_count = 0;
    int          tests_run = 0;
    function automatic logic [7:0] crc8(input logic [55:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 56; i++) c = (c >> 1) ^ (((c[0] ^ d[i]) == 1'b1) ? 8'h8c : 8'h00);
        return c;
    endfunction
    // Family code 2a and the serial number are arbitrary.
    localparam logic [55:0] DATA = 56'h5a3c96e10f272a;
    localparam logic [63:0] ID   = {crc8(DATA), DATA};
    localparam logic [63:0] BAD  = ID ^ 64'h0100000000000000;
    localparam logic [65:0] ALL  = {66{1'b1}};
    localparam logic [65:0] NONE = {2'b11, 64'h0};
    // Timing runs at two cycles per microsecond so that a full search fits the run budget.
    localparam int          US   = 2;
    id_link_master #(.CLOCK_KHZ(US * 1000)) i_dut (.clock(clock), .rst(rst), .start(start),
        .command(command),
        .choose(choose), .busy(busy), .result_valid(result_valid), .result_ready(result_ready),
        .result_data(result_data), .line_in(line), .line_out(line_out), .line_oe_n(line_oe_n));
    id_device_model #(.CYCLES_PER_US(US)) i_device (.clock(clock), .present(present),
        .id_word(id_word),
        .line(line), .pull(pull));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic results();
        if (err_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check_word(input logic [65:0] got, input logic [65:0] exp,
                              input logic [65:0] mask);
        tests_run++;
        if ((got & mask) !== (exp & mask)) begin
            err_count++;
            $display("[FAIL] %0t result %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_flag(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic pulse_start(input logic [7:0] code);
        @(posedge clock);
        start   <= 1'b1;
        command <= code;
        @(posedge clock);
        start <= 1'b0;
        @(negedge clock);
    endtask
    task automatic run(input logic [7:0] code);
        int n;
        n = 0;
        pulse_start(code);
        check_flag(busy, 1'b1);
        while (busy !== 1'b0 && n < 40000) begin
            @(negedge clock);
            n++;
        end
        check_flag(busy, 1'b0);
    endtask
    task automatic take(input logic [65:0] exp, input logic [65:0] mask);
        int n;
        n = 0;
        @(negedge clock);
        while (result_valid !== 1'b1 && n < 100) begin
            @(negedge clock);
            n++;
        end
        check_flag(result_valid, 1'b1);
        check_word(result_data, exp, mask);
        @(posedge clock);
        result_ready <= 1'b1;
        @(posedge clock);
        result_ready <= 1'b0;
    endtask
    task automatic t_read();
        run(8'h33);
        take({2'b11, ID}, ALL);
    endtask
    task automatic t_buffer();
        run(8'h55);
        run(8'hcc);
        // Three results fill the output register and both buffer entries.
        run(8'h55);
        pulse_start(8'h33);
        check_flag(busy, 1'b0);
        take(NONE, ALL);
        take(NONE, ALL);
        take(NONE, ALL);
    endtask
    task automatic t_bad_crc();
        id_word <= BAD;
        run(8'h0f);
        take({2'b10, BAD}, ALL);
        id_word <= ID;
    endtask
    task automatic t_unknown();
        run(8'ha5);
        take(NONE, ALL);
    endtask
    task automatic t_absent();
        present <= 1'b0;
        run(8'hf0);
        take({2'b01, 64'h0}, ALL);
        present <= 1'b1;
    endtask
    task automatic t_search();
        run(8'hf0);
        take({2'b11, ID}, ALL);
    endtask
    initial begin
        rst          <= 1'b1;
        start        <= 1'b0;
        command      <= 8'h00;
        choose       <= 64'h0;
        result_ready <= 1'b0;
        present      <= 1'b1;
        id_word      <= ID;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        t_read();
        t_buffer();
        t_bad_crc();
        t_unknown();
        t_absent();
        t_search();
        results();
    end
    initial begin
        // The scenarios need about 75,000 cycles at this timing scale.
        repeat (100000) @(posedge clock);
        err_count++;
        results();
    end
endmodule // id_link_master_tb
bind id_link_master id_link_properties #(.RESET_LOW_CYCLES(RESET_LOW_CYCLES),
    .RESET_HIGH_CYCLES(RESET_HIGH_CYCLES), .CYCLES_PER_US(CLOCK_KHZ / 1000)) i_props (
    .clock(clock), .rst(rst), .start(start),
    .busy(busy), .result_valid(result_valid), .result_ready(result_ready),
    .result_data(result_data), .line_out(line_out), .line_oe_n(line_oe_n));
`default_nettype wire
